// ### include/scan_tap_consts.vh
`ifndef SCAN_TAP_CONSTS_VH
`define SCAN_TAP_CONSTS_VH

// ----------------------------------------------------------------------------
// Register sizes
// ----------------------------------------------------------------------------
`define IR_WIDTH        3
`define ID_WIDTH        32
`define BSR_WIDTH       51

// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define INS_EXTEST      3'h0
`define INS_IDCODE      3'h1
`define INS_SAMPLE_Z    3'h2
`define INS_SAMPLE      3'h4
`define INS_BYPASS      3'h7
`define IR_CAPTURE_VAL  3'h1

// ----------------------------------------------------------------------------
// Identification word fields
// ----------------------------------------------------------------------------
`define ID_REV_MSB      31
`define ID_REV_LSB      28
`define ID_DEPTH_MSB    27
`define ID_DEPTH_LSB    23
`define ID_WIDTH_MSB    22
`define ID_WIDTH_LSB    18
`define ID_RSVD_MSB     17
`define ID_RSVD_LSB     12
`define ID_MFR_MSB      11
`define ID_MFR_LSB      1
// Field values below are arbitrary, neutral codes
`define ID_REV_VAL      4'h0
`define ID_DEPTH_VAL    5'h0A
`define ID_WIDTH_VAL    5'h05
`define ID_RSVD_VAL     6'h00
`define ID_MFR_VAL      11'h2A5

// ----------------------------------------------------------------------------
// Cell positions in the 51-cell chain (cell n at bit n-1)
// ----------------------------------------------------------------------------
`define CELL_SLEEP      11
`define CELL_SYSCLK     26
`define CELL_BURST_ORD  44
`define CELL_BURST_A1   49
`define CELL_BURST_A0   50

// ----------------------------------------------------------------------------
// Cell positions in the 70-cell wide chain, not built in this block
// ----------------------------------------------------------------------------
`define WIDE_BSR_WIDTH       70   // [R12]
`define WIDE_CELL_SLEEP      16   // [R13]
`define WIDE_CELL_SYSCLK     34   // [R13]
`define WIDE_CELL_UNUSED     53   // [R13]
`define WIDE_CELL_BURST_ORD  63   // [R13]
`define WIDE_CELL_BURST_A1   68   // [R12]
`define WIDE_CELL_BURST_A0   69   // [R12] [R15]

`endif

// ### rtl/sram_boundary_scan_tap.v
// Function
// [R1] Three-bit IR, bypass, 32-bit ID, 51-cell chain
// [R2] Code 000 samples chain, outputs high impedance
// [R3] Code 001 loads ID word, selects ID
// [R4] Code 010 samples chain, outputs high impedance
// [R5] Controller never loads codes 011, 101, 110; the code loads them at IR update and runs them as bypass
// [R6] Code 100 samples chain, no preload update
// [R7] Code 111 selects single-bit bypass register
// [R8] ID holds revision, depth, width fields
// [R9] ID bits 17:12 reserved field
// [R10] ID bits 11:1 manufacturer code
// [R11] ID bit 0 always one
// [R12] Wide organisation chain has 70 cells
// [R13] Wide organisation sleep, clock, mode cell positions
// [R14] Narrow chain sleep 12, clock 27, mode 45
// [R15] Highest cell index 69 or 50
// [R16] Output changes on falling test clock edge
// [R17] IR capture loads 01 into low bits
// [R18] Reset state selects identification instruction
// [R19] New instruction acts only at IR update
// [R20] Standard sixteen-state controller driven by mode select
// [R21] Least significant bit shifts out first
`timescale 1ns/1ps
`include "scan_tap_consts.vh"

module sram_boundary_scan_tap
(
  input  wire                  i_clk,
  input  wire                  i_rst_n,
  input  wire                  i_ce,
  input  wire                  i_tck,
  input  wire                  i_tms,
  input  wire                  i_tdi,
  input  wire [`BSR_WIDTH-1:0] i_pin_ring,
  output reg                   o_tdo,
  output reg                   o_tdo_oe,
  output reg                   o_outputs_hiz
);

  // --------------------------------------------------------------------------
  // Controller states
  // --------------------------------------------------------------------------
  localparam [3:0] ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
                   ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7,
                   ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB,
                   ST_EX1_IR = 4'hC, ST_PAU_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF;

  // --------------------------------------------------------------------------
  // Pin synchronisers and test clock edge detect
  // --------------------------------------------------------------------------
  reg [2:0]             tck_sync_ff;
  reg [1:0]             tms_sync_ff;
  reg [1:0]             tdi_sync_ff;
  reg [`BSR_WIDTH-1:0]  ring_meta_ff;
  reg [`BSR_WIDTH-1:0]  ring_sync_ff;
  reg [3:0]             state_ff;
  reg [3:0]             nxt_state;
  reg [`IR_WIDTH-1:0]   ir_shift_ff;
  reg [`IR_WIDTH-1:0]   ir_ff;
  reg                   bypass_ff;
  reg [`ID_WIDTH-1:0]   id_shift_ff;
  reg [`BSR_WIDTH-1:0]  bsr_ff;
  wire                  tck_rise;
  wire                  tck_fall;
  wire                  tms_s;
  wire                  tdi_s;
  wire [`ID_WIDTH-1:0]  id_word;

  // --------------------------------------------------------------------------
  // Instruction decode
  // --------------------------------------------------------------------------
  // Codes that put the boundary scan chain on the serial path
  function selects_ring;
    input [`IR_WIDTH-1:0] code;
    begin
      selects_ring = (code == `INS_EXTEST) || (code == `INS_SAMPLE_Z) || (code == `INS_SAMPLE);
    end
  endfunction

  // Codes that float the memory's functional outputs
  function floats_pins;
    input [`IR_WIDTH-1:0] code;
    begin
      floats_pins = (code == `INS_EXTEST) || (code == `INS_SAMPLE_Z);
    end
  endfunction

  assign tck_rise = tck_sync_ff[1] & ~tck_sync_ff[2];
  assign tck_fall = ~tck_sync_ff[1] & tck_sync_ff[2];
  assign tms_s    = tms_sync_ff[1];
  assign tdi_s    = tdi_sync_ff[1];

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      tck_sync_ff  <= 3'h0;
      tms_sync_ff  <= 2'h3;
      tdi_sync_ff  <= 2'h3;
      ring_meta_ff <= {`BSR_WIDTH{1'b0}};
      ring_sync_ff <= {`BSR_WIDTH{1'b0}};
    end
    else if (i_ce)
    begin
      tck_sync_ff  <= {tck_sync_ff[1:0], i_tck};
      tms_sync_ff  <= {tms_sync_ff[0], i_tms};
      tdi_sync_ff  <= {tdi_sync_ff[0], i_tdi};
      ring_meta_ff <= i_pin_ring;
      ring_sync_ff <= ring_meta_ff;
    end
  end

  // --------------------------------------------------------------------------
  // Identification word
  // --------------------------------------------------------------------------
  assign id_word = {`ID_REV_VAL, `ID_DEPTH_VAL, `ID_WIDTH_VAL,   // [R8]
                    `ID_RSVD_VAL,                                  // [R9]
                    `ID_MFR_VAL,                                   // [R10]
                    1'b1};                                         // [R11]

  // --------------------------------------------------------------------------
  // Controller next state
  // --------------------------------------------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)                                                // [R20]
      ST_RESET:  nxt_state = tms_s ? ST_RESET  : ST_IDLE;
      ST_IDLE:   nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nxt_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt_state = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  nxt_state = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt_state = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nxt_state = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nxt_state = tms_s ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: nxt_state = tms_s ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: nxt_state = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  nxt_state = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt_state = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nxt_state = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nxt_state = tms_s ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt_state = tms_s ? ST_SEL_DR : ST_IDLE;
      default:   nxt_state = ST_RESET;
    endcase
  end

  // --------------------------------------------------------------------------
  // Rising test clock: state, instruction and data registers
  // --------------------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_ff    <= ST_RESET;
      ir_shift_ff <= `IR_CAPTURE_VAL;
      ir_ff       <= `INS_IDCODE;                                  // [R18]
      bypass_ff   <= 1'b0;
      id_shift_ff <= {`ID_WIDTH{1'b0}};
      bsr_ff      <= {`BSR_WIDTH{1'b0}};
    end
    else if (i_ce && tck_rise)                                     // [R16]
    begin
      state_ff <= nxt_state;
      case (state_ff)
        ST_RESET:
          ir_ff <= `INS_IDCODE;                                    // [R18]
        ST_CAP_IR:
          ir_shift_ff <= {1'b0, 2'h1};                             // [R17]
        ST_SH_IR:
          ir_shift_ff <= {tdi_s, ir_shift_ff[`IR_WIDTH-1:1]};      // [R21]
        ST_UPD_IR:
          ir_ff <= ir_shift_ff;                                    // [R19] [R5]
        // Only the narrow chain is built; the wide layout stays in the header [R12] [R13]
        ST_CAP_DR:
        begin
          bypass_ff <= 1'b0;
          if (ir_ff == `INS_IDCODE)
            id_shift_ff <= id_word;                                // [R3]
          else if (selects_ring(ir_ff))
            bsr_ff <= ring_sync_ff;                                // [R2] [R4] [R6] [R14]
        end
        ST_SH_DR:
        begin
          if (ir_ff == `INS_IDCODE)
            id_shift_ff <= {tdi_s, id_shift_ff[`ID_WIDTH-1:1]};    // [R21]
          else if (selects_ring(ir_ff))
            bsr_ff <= {tdi_s, bsr_ff[`BSR_WIDTH-1:1]};             // [R1] [R15]
          else
            bypass_ff <= tdi_s;                                    // [R7]
        end
        default:
          ;                                                        // Update-DR loads no preset [R6]
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Falling test clock: serial output; output float control on every enabled clock
  // --------------------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_tdo         <= 1'b0;
      o_tdo_oe      <= 1'b0;
      o_outputs_hiz <= 1'b0;
    end
    else if (i_ce)
    begin
      o_outputs_hiz <= floats_pins(ir_ff);                         // [R2] [R4]
      if (tck_fall)                                                // [R16]
      begin
        o_tdo_oe <= (state_ff == ST_SH_DR) || (state_ff == ST_SH_IR);
        if (state_ff == ST_SH_IR)
          o_tdo <= ir_shift_ff[0];
        else if (ir_ff == `INS_IDCODE)
          o_tdo <= id_shift_ff[0];                                 // [R21]
        else if (selects_ring(ir_ff))
          o_tdo <= bsr_ff[0];
        else
          o_tdo <= bypass_ff;                                      // [R7]
      end
    end
  end

endmodule

// ### tb/scan_ctl_model.sv
`timescale 1ns/1ps
module scan_ctl_model
(
  input  wire i_clk,
  input  wire i_tdo,
  output reg  o_tck,
  output reg  o_tms,
  output reg  o_tdi
);
  reg nc;
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // ----------------------------------------
  // One tck period, 4 clk low then 4 high
  // ----------------------------------------
  task step(input t, input d, output q);
  begin
    @(negedge i_clk);
    o_tms = t;
    o_tdi = d;
    repeat (3) @(negedge i_clk);
    o_tck = 1'b1;
    q = i_tdo;
    repeat (4) @(negedge i_clk);
    o_tck = 1'b0;
    o_tdi = ~d; // Line is a don't care now, keep it moving
  end
  endtask
  task shift(input integer n, input [63:0] d, output [63:0] q);
    integer i;
  begin
    q = 64'h0;
    for (i = 0; i < n; i = i + 1)
      step(i == n - 1, d[i], q[i]);
  end
  endtask
  task reset_tap;
  begin
    repeat (5) step(1'b1, 1'b0, nc);
    step(1'b0, 1'b0, nc);
  end
  endtask
  task ir(input [2:0] c, output [63:0] q);
  begin
    step(1'b1, 1'b0, nc);
    step(1'b1, 1'b0, nc);
    step(1'b0, 1'b0, nc);
    step(1'b0, 1'b0, nc);
    shift(3, {61'h0, c}, q);
    step(1'b1, 1'b0, nc);
    step(1'b0, 1'b0, nc);
  end
  endtask
  task dr(input integer n, input [63:0] d, output [63:0] q);
  begin
    step(1'b1, 1'b0, nc);
    step(1'b0, 1'b0, nc);
    step(1'b0, 1'b0, nc);
    shift(n, d, q);
    step(1'b1, 1'b0, nc);
    step(1'b0, 1'b0, nc);
  end
  endtask
endmodule

// ### tb/sram_boundary_scan_tap_bench.sv
`timescale 1ns/1ps
`include "scan_tap_consts.vh"
module sram_boundary_scan_tap_bench;
  localparam [31:0] ID = {`ID_REV_VAL, `ID_DEPTH_VAL, `ID_WIDTH_VAL, `ID_RSVD_VAL, `ID_MFR_VAL, 1'b1};
  localparam [50:0] RING = 51'h5A3C00F812D47;
  reg         clk = 1'b0;
  reg         rst_n;
  reg         ce;
  reg  [50:0] ring;
  reg  [63:0] q;
  wire        tck, tms, tdi, tdo, oe, hiz;
  integer     fails, checks;
  always #5 clk = ~clk;
  sram_boundary_scan_tap u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_pin_ring(ring), .o_tdo(tdo), .o_tdo_oe(oe), .o_outputs_hiz(hiz));
  scan_ctl_model u_ctl (.i_clk(clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  task chk(input string nm, input [63:0] e, input [63:0] g);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task results;
  begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task t_id;
  begin
    u_ctl.dr(32, 64'h0, q);
    chk("idcode", {32'h0, ID}, q);
    chk("hiz", 64'h0, {63'h0, hiz});
    chk("tdo enable", 64'h0, {63'h0, oe});
  end
  endtask
  task t_bypass;
  begin
    u_ctl.ir(`INS_BYPASS, q);
    chk("ir capture", 64'h1, q);
    u_ctl.dr(4, 64'hB, q);
    chk("bypass", 64'h6, q);
  end
  endtask
  task t_ring(input [2:0] c, input h);
  begin
    u_ctl.ir(c, q);
    chk("hiz", {63'h0, h}, {63'h0, hiz});
    u_ctl.dr(51, 64'h0, q);
    chk("ring", {13'h0, RING}, q);
    ring = ~RING;
    u_ctl.dr(51, {13'h0, RING}, q);
    chk("recapture", {13'h0, ~RING}, q);
    ring = RING;
  end
  endtask
  task t_freeze_reset;
  begin
    ce = 1'b0;
    // Test clock edges with the enable low must not reach the controller
    u_ctl.reset_tap;
    ce = 1'b1;
    chk("hiz frozen", 64'h1, {63'h0, hiz});
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    u_ctl.step(1'b0, 1'b0, q[0]);
    t_id;
  end
  endtask
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    ring = RING;
    fails = 0;
    checks = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    u_ctl.reset_tap;
    t_id;
    t_bypass;
    t_ring(`INS_EXTEST, 1'b1);
    t_ring(`INS_SAMPLE, 1'b0);
    t_ring(`INS_SAMPLE_Z, 1'b1);
    t_freeze_reset;
    results;
  end
  initial
  begin
    #900000;
    fails = fails + 1;
    results;
  end
endmodule

// ### tb/sram_boundary_scan_tap_chk.sv
`timescale 1ns/1ps
module sram_boundary_scan_tap_chk
(
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_tck,
  input wire i_tms,
  input wire o_tdo,
  input wire o_tdo_oe,
  input wire o_outputs_hiz
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_tck_low;
    !$past(i_tck, 2);
  endsequence
  sequence s_tck_high;
    $past(i_tck, 2);
  endsequence
  a_tdo_on_fall: assert property ($changed(o_tdo) |-> s_tck_low)
    else $error("tdo moved away from a tck fall");
  a_oe_on_fall: assert property ($changed(o_tdo_oe) |-> s_tck_low)
    else $error("tdo enable moved away from a tck fall");
  a_hiz_on_rise: assert property ($changed(o_outputs_hiz) |-> s_tck_high)
    else $error("hiz moved away from a tck rise");
  a_hiz_at_update: assert property ($changed(o_outputs_hiz) |-> !o_tdo_oe)
    else $error("hiz moved during a shift");
  a_oe_min_len: assert property ($rose(o_tdo_oe) |-> o_tdo_oe[*8])
    else $error("shift window shorter than a tck period");
  a_oe_enter_shift: assert property ($rose(o_tdo_oe) |-> !$past(i_tms, 6))
    else $error("shift entered with tms high");
  a_oe_leave_shift: assert property ($fell(o_tdo_oe) |-> $past(i_tms, 6))
    else $error("shift left with tms low");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_tdo && !o_tdo_oe && !o_outputs_hiz)
    else $error("outputs not quiet after reset");
  a_ce_freeze: assert property (!i_ce |=> $stable(o_tdo) && $stable(o_outputs_hiz))
    else $error("outputs moved with enable low");
endmodule
bind sram_boundary_scan_tap sram_boundary_scan_tap_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_ce(i_ce), .i_tck(i_tck), .i_tms(i_tms), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
  .o_outputs_hiz(o_outputs_hiz));
